// ===== rtl/brg_params.svh
/*
  Offsets, fields, reset values and rates of the baud rate generator.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef BRG_PARAMS_SVH
`define BRG_PARAMS_SVH
`define ADR_RELOAD    8'h00
`define ADR_SHIFT_BUF 8'h04
`define ADR_STATUS    8'h08
`define ADR_CONTROL   8'h0c
`define RELOAD_RST    8'h00
`define STATUS_RST    8'h00
`define STATUS_RW_MSK 8'hc0
`define CTRL_RST      3'h0
`define CTRL_RSTART   2
`define TICK_DIV      2'h2
`define HALVES_SPI    5'h10
`define HALVES_I2C    5'h12
`endif

// ===== rtl/brg_pkg.sv
/*
  Types shared by the baud rate generator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package brg_pkg;
  // Port operating mode
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SPI = 2'b01,
    MODE_I2C = 2'b10
  } mode_e;
  // Sequencer state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_RS_W = 2'b10,
    ST_RS_C = 2'b11
  } state_e;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;
endpackage

// ===== rtl/serial_port_baud_rate_generator.sv
/*
  Reload based rate counter making the serial clock of a synchronous
  serial port in SPI host and I2C host modes, with a Wishbone slave.
  Assumes CLK is the oscillator clock, and SCL_I and SDA_I come from
  pins outside the clock domain; SCL pin drive is resolved outside.
*/
`timescale 1ns/1ns
`include "brg_params.svh"

// Functional notes
// - One rate counter clocks both host modes
// - Reload copies register value into counter
// - Shift buffer write starts the countdown
// - Counter stops after operation, clock holds
// - Reload twice per serial clock period
// - Reload conditions depend on port mode
// - Rate is oscillator over four times reload+1
// - Status: two upper RW, six RO, reset 8'h02 (clock level high)
// - Repeated start: count down before SCL release
module serial_port_baud_rate_generator (
  input  wire logic           CLK,
  input  wire logic           RST,
  input  wire brg_pkg::wb_req_s WB_REQ,
  output logic                WB_ACK_O,
  output logic [31:0]         WB_DAT_O,
  input  wire logic           SCL_I,
  input  wire logic           SDA_I,
  output logic                SCL_O,
  output logic                SCL_OE,
  output logic                BUSY
);
  import brg_pkg::*;

  // Bus state
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  // Software visible registers
  logic [7:0]  reload_q, reload_d;    // Rate reload value
  logic [7:0]  sbuf_q, sbuf_d;        // Shift buffer contents
  logic [7:0]  stat_rw_q, stat_rw_d;  // Writable status bits
  logic [2:0]  ctrl_q, ctrl_d;        // Mode and repeated start
  // Counter and sequencer
  logic [7:0]  cnt_q, cnt_d;          // Rate counter
  logic [1:0]  div_q, div_d;          // Tick divider
  logic [4:0]  halves_q, halves_d;    // Half periods left
  logic        scl_q, scl_d;          // Serial clock level
  state_e      st_q, st_d;
  // Pin synchronisers
  logic [1:0]  scl_sy_q, sda_sy_q;

  // Decoded strobes
  logic        req, wr, bus_wr_sbuf, bus_wr_ctrl;
  logic        tick, stretch, cnt_en, roll, load;
  logic [7:0]  status;
  mode_e       mode;

  assign mode   = mode_e'(ctrl_q[1:0]);
  // New request only while no answer stands
  assign req    = WB_REQ.cyc && WB_REQ.stb && !ack_q;
  assign wr     = req && WB_REQ.we && WB_REQ.sel[0];
  assign bus_wr_sbuf = wr && (WB_REQ.adr == `ADR_SHIFT_BUF);
  assign bus_wr_ctrl = wr && (WB_REQ.adr == `ADR_CONTROL);
  // Busy in bit 0, clock level in bit 1, bits 5:2 read zero
  assign status = {stat_rw_q[7:6], 4'h0, scl_q, (st_q != ST_IDLE)};

  // Two flop synchronisers for pin inputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      scl_sy_q <= 2'h0;
      sda_sy_q <= 2'h0;
    end else begin
      scl_sy_q <= {scl_sy_q[0], SCL_I};
      sda_sy_q <= {sda_sy_q[0], SDA_I};
    end
  end

  // Tick: two oscillator cycles, so a half period of reload+1 ticks
  // gives the four times reload+1 full period
  assign tick = (div_q == `TICK_DIV - 2'h1);
  // I2C clock arbitration: a released SCL held low freezes the count
  assign stretch = (mode == MODE_I2C) && scl_q && !scl_sy_q[1]
                   && (st_q == ST_RUN);
  assign cnt_en = tick && !stretch && (st_q == ST_RUN || st_q == ST_RS_C);
  // Rollover when the counter sits at zero on a counting tick
  assign roll = cnt_en && (cnt_q == 8'h00);
  // Reload strobe, chosen per mode and sequence step
  assign load = roll || (bus_wr_sbuf && mode != MODE_OFF)
             || (st_q == ST_RS_W && sda_sy_q[1]);

  // Bus next values
  always_comb begin
    ack_d     = req;
    rdat_d    = 32'h0;
    reload_d  = reload_q;
    sbuf_d    = sbuf_q;
    stat_rw_d = stat_rw_q;
    ctrl_d    = ctrl_q;
    if (req && !WB_REQ.we) begin
      // Read mux, unmapped offsets answer zero
      unique case (WB_REQ.adr)
        `ADR_RELOAD:    rdat_d = {24'h0, reload_q};
        `ADR_SHIFT_BUF: rdat_d = {24'h0, sbuf_q};
        `ADR_STATUS:    rdat_d = {24'h0, status};
        `ADR_CONTROL:   rdat_d = {29'h0, ctrl_q};
        default:        rdat_d = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (WB_REQ.adr)
        `ADR_RELOAD:    reload_d = WB_REQ.dat[7:0];
        `ADR_SHIFT_BUF: sbuf_d = WB_REQ.dat[7:0];
        // Only the upper two status bits take writes
        `ADR_STATUS:    stat_rw_d = WB_REQ.dat[7:0] & `STATUS_RW_MSK;
        `ADR_CONTROL:   ctrl_d = WB_REQ.dat[2:0];
        default:        ctrl_d = ctrl_q;
      endcase
    end
    // Repeated start request clears once taken up
    if (st_q == ST_RS_W && !bus_wr_ctrl) begin
      ctrl_d[`CTRL_RSTART] = 1'b0;
    end
  end

  // Bus registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0;
      reload_q  <= `RELOAD_RST;
      sbuf_q    <= 8'h00;
      stat_rw_q <= `STATUS_RST;
      ctrl_q    <= `CTRL_RST;
    end else begin
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      reload_q  <= reload_d;
      sbuf_q    <= sbuf_d;
      stat_rw_q <= stat_rw_d;
      ctrl_q    <= ctrl_d;
    end
  end

  // Counter and sequencer next values
  always_comb begin
    div_d    = tick ? 2'h0 : div_q + 2'h1;
    cnt_d    = cnt_q;
    halves_d = halves_q;
    scl_d    = scl_q;
    st_d     = st_q;
    // Reload copies the register; otherwise count down
    if (load) begin
      cnt_d = reload_q;
    end else if (cnt_en) begin
      cnt_d = cnt_q - 8'h01;
    end
    unique case (st_q)
      ST_IDLE: begin
        // Write to the shift buffer starts counting
        if (bus_wr_sbuf && mode != MODE_OFF) begin
          st_d     = ST_RUN;
          halves_d = (mode == MODE_I2C) ? `HALVES_I2C : `HALVES_SPI;
        end else if (ctrl_q[`CTRL_RSTART] && mode == MODE_I2C) begin
          st_d = ST_RS_W;
        end
      end
      ST_RUN: begin
        // Each rollover is one half period of the clock
        if (roll) begin
          scl_d    = !scl_q;
          halves_d = halves_q - 5'h01;
          // Last half done: stop, clock keeps its level
          if (halves_q == 5'h01) begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_RS_W: begin
        // Data line released and seen high: counter loaded
        if (sda_sy_q[1]) begin
          st_d = ST_RS_C;
        end
      end
      ST_RS_C: begin
        // Count reached zero: release the clock line
        if (roll) begin
          scl_d = 1'b1;
          st_d  = ST_IDLE;
        end
      end
    endcase
  end

  // Counter and sequencer registers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q    <= 2'h0;
      cnt_q    <= 8'h00;
      halves_q <= 5'h00;
      scl_q    <= 1'b1;
      st_q     <= ST_IDLE;
    end else begin
      div_q    <= div_d;
      cnt_q    <= cnt_d;
      halves_q <= halves_d;
      scl_q    <= scl_d;
      st_q     <= st_d;
    end
  end

  // Pin drive: push-pull in SPI, open drain in I2C
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SCL_O  <= 1'b0;
      SCL_OE <= 1'b0;
      BUSY   <= 1'b0;
    end else begin
      SCL_O  <= (mode == MODE_SPI) ? scl_d : 1'b0;
      SCL_OE <= (mode == MODE_SPI) || (mode == MODE_I2C && !scl_d);
      BUSY   <= (st_d != ST_IDLE);
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_ack_single: assert property (ack_q |=> !ack_q)
    else $error("ack stood two cycles");
  a_ack_answer: assert property (req |=> ack_q)
    else $error("request not answered next cycle");
  a_start_write: assert property (
    (bus_wr_sbuf && mode != MODE_OFF && st_q == ST_IDLE)
      |=> (st_q == ST_RUN && cnt_q == $past(reload_q)))
    else $error("shift buffer write did not start counter");
  a_roll_reload: assert property (
    roll |=> (cnt_q == $past(reload_q)))
    else $error("rollover did not reload counter");
  a_half_toggle: assert property (
    (roll && st_q == ST_RUN) |=> (scl_q != $past(scl_q)))
    else $error("clock did not toggle at rollover");
  a_idle_hold: assert property (
    (st_q == ST_IDLE && !roll) |=> (scl_q == $past(scl_q) || st_q == ST_RS_C))
    else $error("clock moved while stopped");
  a_count_down: assert property (
    (cnt_en && !load) |=> (cnt_q == $past(cnt_q) - 8'h01))
    else $error("counter did not decrement");
  a_tick_rate: assert property (
    tick |=> !tick ##1 tick)
    else $error("tick spacing wrong");
  a_stretch_freeze: assert property (
    (stretch && !load) |=> (cnt_q == $past(cnt_q)))
    else $error("counter ran while clock stretched");
  a_rs_release: assert property (
    (st_q == ST_RS_C && roll) |=> (scl_q && st_q == ST_IDLE))
    else $error("repeated start did not release clock");
  a_status_ro: assert property (
    (wr && WB_REQ.adr == `ADR_STATUS)
      |=> (stat_rw_q == ($past(WB_REQ.dat[7:0]) & `STATUS_RW_MSK)))
    else $error("read only status bits written");

  c_spi_byte: cover property (st_q == ST_RUN && mode == MODE_SPI
                              ##1 st_q == ST_IDLE);
  c_i2c_byte: cover property (st_q == ST_RUN && mode == MODE_I2C
                              ##1 st_q == ST_IDLE);
  c_rstart: cover property (st_q == ST_RS_C ##1 st_q == ST_IDLE);
  c_stretch: cover property (stretch);
endmodule

// ===== test/bus_peer.sv
/*
  Far side bus device: wire levels with pull-ups, clock stretching.
  Assumes the host drives the clock open drain in I2C mode.
*/
`timescale 1ns/1ns
module bus_peer (
  input  wire logic       clk,
  input  wire logic       scl_o,
  input  wire logic       scl_oe,
  input  wire logic       sda_low, // Hold data line low
  input  wire logic [7:0] hold,    // Stretch length in clocks
  output logic            scl_w,   // Resolved clock wire
  output logic            sda_w    // Resolved data wire
);
  logic [7:0] cnt_q; // Stretch countdown
  // Start with no stretch, so a released wire reads high at once
  initial begin
    cnt_q = 8'h00;
  end
  // Reload while host pulls low, so stretch starts at release
  always @(posedge clk) begin
    if (scl_oe && !scl_o) begin
      cnt_q <= hold;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // Pull-ups win only when nobody pulls low
  assign scl_w = scl_oe ? scl_o : (cnt_q == 8'h00);
  assign sda_w = !sda_low;
endmodule

// ===== test/serial_port_baud_rate_generator_test.sv
/*
  Self-checking bench: registers, SPI and I2C clock, repeated start.
  Assumes bus_peer as the far side on the clock and data wires.
*/
`timescale 1ns/1ns
module serial_port_baud_rate_generator_test;
  import brg_pkg::*;
  logic        clk, rst, ack, busy, scl, oe, scl_w, sda_w, sda_low;
  logic [31:0] dat;
  logic [7:0]  hold;
  wb_req_s     req;
  int          compares, miscompares;
  serial_port_baud_rate_generator uut (.CLK(clk), .RST(rst),
    .WB_REQ(req), .WB_ACK_O(ack), .WB_DAT_O(dat), .SCL_I(scl_w),
    .SDA_I(sda_w), .SCL_O(scl), .SCL_OE(oe), .BUSY(busy));
  bus_peer peer (.clk(clk), .scl_o(scl), .scl_oe(oe),
    .sda_low(sda_low), .hold(hold), .scl_w(scl_w), .sda_w(sda_w));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One classic cycle; waits for ack, then idles a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, w, a, 4'hf, {24'h0, d}};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) miscompares++;
    q = dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask
  // Cycles until the clock wire changes, capped
  task automatic tgl(output int n, input int lim);
    logic l;
    l = scl_w;
    n = 0;
    while (scl_w === l && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  // Reset values, masks, unmapped place
  task automatic t_regs;
    logic [31:0] q;
    wb(1'b0, 8'h00, 8'h00, q); check(q, 32'h0);
    wb(1'b0, 8'h08, 8'h00, q); check(q & 32'hfc, 32'h0);
    wb(1'b1, 8'h08, 8'hff, q);
    wb(1'b0, 8'h08, 8'h00, q); check(q & 32'hfc, 32'hc0);
    wb(1'b1, 8'h00, 8'h5a, q);
    wb(1'b0, 8'h00, 8'h00, q); check(q, 32'h5a);
    wb(1'b0, 8'h30, 8'h00, q); check(q, 32'h0);
  endtask
  // SPI: half 2*(R+1), 16 halves, then hold
  task automatic t_spi;
    logic [31:0] q;
    int          n, k;
    wb(1'b1, 8'h00, 8'h02, q);
    wb(1'b1, 8'h0c, 8'h01, q);
    wb(1'b1, 8'h04, 8'ha5, q);
    @(posedge clk);
    check({31'h0, busy}, 32'h1);
    tgl(n, 99);
    tgl(n, 99); check(n, 32'h6);
    tgl(n, 99); check(n, 32'h6);
    for (k = 3; k < 16; k++) tgl(n, 99);
    tgl(n, 60); check(n, 32'h3c);
    check({31'h0, busy}, 32'h0);
  endtask
  // I2C: low half exact, stretched high frozen, 18 halves
  task automatic t_i2c;
    logic [31:0] q;
    int          n, k;
    wb(1'b1, 8'h00, 8'h03, q); // Reload above 2
    wb(1'b1, 8'h0c, 8'h02, q);
    wb(1'b1, 8'h04, 8'h3c, q);
    tgl(n, 99);
    tgl(n, 99); check(n, 32'h8);
    tgl(n, 99);
    hold <= 8'h14;
    tgl(n, 99); check({31'h0, n >= 28 && n <= 33}, 32'h1);
    tgl(n, 99);
    hold <= 8'h00;
    for (k = 5; k < 18; k++) tgl(n, 99);
    tgl(n, 60); check(n, 32'h3c);
    check({31'h0, scl_w}, 32'h1);
  endtask
  // Repeated start waits for data high, counts, releases
  task automatic t_rs;
    logic [31:0] q;
    int          n;
    sda_low <= 1'b1;
    wb(1'b1, 8'h0c, 8'h06, q);
    repeat (30) @(posedge clk);
    check({31'h0, busy}, 32'h1);
    sda_low <= 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 99) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, n >= 8 && n <= 14}, 32'h1);
    check({31'h0, scl_w}, 32'h1);
    wb(1'b0, 8'h0c, 8'h00, q); check(q & 32'h4, 32'h0);
  endtask
  // Hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
  initial begin
    rst = 1'b1;
    req = '0;
    sda_low = 1'b0;
    hold = 8'h00;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_spi;
    t_i2c;
    t_rs;
    end_of_test;
  end
endmodule
